// File: verilog/operating_mode_controller.sv
// operating-mode controller: mode state, per-function enables, crc strap and recovery
//
// Summary of operation
// - strap pulled low enables crc, open disables
// - sample strap: init/restart, supply ok, por, reset low
// - filter strap in delay, latch at reset rise
// - frame 67AAAA0E turns crc on
// - frame E7AAAAC3 turns crc off
// - power-on enters init, waits for host
// - init: watchdog fixed, long window after reset
// - init: drivers, pump, sense, can, cyclic off
// - development mode turns can on in init
// - normal: regulator on, all functions configurable
// - normal: supervision and monitoring enabled
// - normal: cyclic sense and wake configurable
// - stop: regulator on in low power
// - stop: reject writes except exempt ones
// - stop: wake events interrupt, never change mode
// - stop: settings frozen, bridge pump sense off
// - stop: low-side braking still possible
// - sleep: regulator, watchdog, bridge, pump, sense off; rest frozen
// - sleep: low-side braking still possible
// - restart: reset asserted, functions off
module operating_mode_controller
    import opmode_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYCLES,
    parameter int FILT_CYCLES = STRAP_FILTER_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        crc_strap_pin,
    input  wire logic        regulator_above_threshold,
    input  wire logic        por_flag,
    input  wire logic        sw_dev_mode,
    input  wire logic        restart_event,
    input  wire logic        wake_event,
    input  wire logic        park_brake_event,
    input  wire logic        ov_brake_event,
    input  wire logic        frame_valid,
    input  wire logic [31:0] frame_data,
    input  wire logic        write_req,
    input  wire logic        write_exempt,
    input  wire logic [2:0]  mode_req,
    input  wire logic        cfg_watchdog_unit,
    input  wire logic        cfg_high_side_switches,
    input  wire logic        cfg_bridge_drivers,
    input  wire logic        cfg_charge_pump,
    input  wire logic        cfg_current_sense_amplifier,
    input  wire logic        cfg_can,
    input  wire logic        cfg_can_wake_capable,
    input  wire logic        cfg_cyclic_sense,
    input  wire logic        cfg_cyclic_wake,
    input  wire logic        low_side_brake_req,
    output logic [2:0]       mode_state,
    output logic             reset_output_low_active,
    output logic             crc_enable,
    output logic             main_regulator_output,
    output logic             main_regulator_low_power,
    output logic             watchdog_unit_en,
    output logic             watchdog_long_window,
    output logic             watchdog_config_allowed,
    output logic             high_side_switches_en,
    output logic             bridge_drivers_en,
    output logic             bridge_low_side_en,
    output logic             charge_pump_en,
    output logic             current_sense_amplifier_en,
    output logic             can_en,
    output logic             can_wake_capable,
    output logic             cyclic_sense_en,
    output logic             cyclic_wake_en,
    output logic             supervision_en,
    output logic             write_rejected,
    output logic             wake_interrupt
);
    ////////////////////////////////////////////////////////////////////////////////
    // mode state

    op_mode_t state_reg;
    op_mode_t state_next;
    logic     rst_out_reg;
    logic     rst_out_next;
    localparam int DW = $clog2(RESET_DELAY + 1);

    logic [DW-1:0] delay_reg;

    wire delay_done = (delay_reg == DW'(RESET_DELAY - 1));
    wire in_init    = (state_reg == MODE_INIT);
    wire in_normal  = (state_reg == MODE_NORMAL);
    wire in_stop    = (state_reg == MODE_STOP);
    wire in_sleep   = (state_reg == MODE_SLEEP);
    wire in_restart = (state_reg == MODE_RESTART);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MODE_INIT: begin
                // wait for host to finish startup
                if (rst_out_reg && mode_req == REQ_NORMAL) begin
                    state_next = MODE_NORMAL;
                end
            end
            MODE_NORMAL: begin
                if (restart_event) begin
                    state_next = MODE_RESTART;
                end else if (mode_req == REQ_STOP) begin
                    state_next = MODE_STOP;
                end else if (mode_req == REQ_SLEEP) begin
                    state_next = MODE_SLEEP;
                end else if (mode_req == REQ_SOFTRST) begin
                    state_next = MODE_INIT;
                end
            end
            MODE_STOP: begin
                // wake events never leave stop; only host request or restart event does
                if (restart_event) begin
                    state_next = MODE_RESTART;
                end else if (mode_req == REQ_NORMAL) begin
                    state_next = MODE_NORMAL;
                end else if (mode_req == REQ_SOFTRST) begin
                    state_next = MODE_INIT;
                end
            end
            MODE_SLEEP: begin
                if (wake_event || restart_event) begin
                    state_next = MODE_RESTART;
                end
            end
            MODE_RESTART: begin
                if (rst_out_reg) begin
                    state_next = MODE_NORMAL;
                end
            end
            default: state_next = MODE_INIT;
        endcase
    end

    // reset output held low through the delay in init and restart
    wire need_delay = (in_init || in_restart) && !rst_out_reg;
    assign rst_out_next = (state_next == MODE_RESTART && !in_restart) ? 1'b0 :
                          (state_next == MODE_INIT && !in_init) ? 1'b0 :
                          (need_delay && delay_done && regulator_above_threshold) ? 1'b1 :
                          rst_out_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= MODE_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_out_reg <= 1'b0;
        end else begin
            rst_out_reg <= rst_out_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_reg <= '0;
        end else if (!need_delay || !regulator_above_threshold || delay_done) begin
            delay_reg <= '0;
        end else begin
            delay_reg <= delay_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crc strap and recovery frames

    strap_if sif ();

    strap_filter #(
        .FILT_CYCLES (FILT_CYCLES)
    ) u_filter (
        .clk         (clk),
        .rst_b       (rst_b),
        .strap_level (crc_strap_pin),
        .sif         (sif)
    );

    logic crc_reg;
    logic crc_next;
    logic rst_out_d_reg;

    assign sif.sample_en = (in_init || in_restart) && regulator_above_threshold
                         && por_flag && !rst_out_reg;

    wire rst_rise   = rst_out_reg && !rst_out_d_reg;
    wire latch_ok   = rst_rise && (in_init || in_restart) && por_flag;
    // low level means pulled down, which enables crc
    wire strap_crc  = !sif.filt_level;
    wire frame_on   = frame_valid && in_normal && (frame_data == CRC_ON_FRAME);
    wire frame_off  = frame_valid && in_normal && (frame_data == CRC_OFF_FRAME);

    assign crc_next = latch_ok ? strap_crc :
                      frame_on ? 1'b1 :
                      frame_off ? 1'b0 :
                      crc_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_reg       <= CRC_EN_RST;
            rst_out_d_reg <= 1'b0;
        end else begin
            crc_reg       <= crc_next;
            rst_out_d_reg <= rst_out_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-function enables; frozen values live in the config inputs, which the
    // host must not change in stop or sleep

    wire cfg_mode = in_normal;
    wire frz_mode = in_stop || in_sleep;
    wire wd_next  = in_init || (cfg_mode && cfg_watchdog_unit)
                  || (in_stop && cfg_watchdog_unit);
    wire hs_next  = (cfg_mode || frz_mode) && cfg_high_side_switches;
    wire bd_next  = cfg_mode && cfg_bridge_drivers;
    wire ls_next  = (cfg_mode && cfg_bridge_drivers)
                  || (frz_mode && low_side_brake_req);
    wire cp_next  = cfg_mode && cfg_charge_pump;
    wire csa_next = cfg_mode && cfg_current_sense_amplifier;
    wire can_next = (in_init && sw_dev_mode) || ((cfg_mode || in_stop) && cfg_can)
                  || (in_sleep && cfg_can && !cfg_can_wake_capable);
    wire canw_nxt = in_sleep && cfg_can && cfg_can_wake_capable;
    wire cs_next  = (cfg_mode || frz_mode) && cfg_cyclic_sense;
    wire cw_next  = (cfg_mode || frz_mode) && cfg_cyclic_wake;
    wire reg_next = !in_sleep;
    wire lp_next  = in_stop;
    wire rej_next = in_stop && write_req && !write_exempt;
    wire irq_next = in_stop && (wake_event || park_brake_event || ov_brake_event);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_state                 <= 3'h0;
            reset_output_low_active    <= 1'b0;
            crc_enable                 <= CRC_EN_RST;
            main_regulator_output      <= 1'b1;
            main_regulator_low_power   <= 1'b0;
            watchdog_unit_en           <= 1'b0;
            watchdog_long_window       <= 1'b0;
            watchdog_config_allowed    <= 1'b0;
            high_side_switches_en      <= 1'b0;
            bridge_drivers_en          <= 1'b0;
            bridge_low_side_en         <= 1'b0;
            charge_pump_en             <= 1'b0;
            current_sense_amplifier_en <= 1'b0;
            can_en                     <= 1'b0;
            can_wake_capable           <= 1'b0;
            cyclic_sense_en            <= 1'b0;
            cyclic_wake_en             <= 1'b0;
            supervision_en             <= 1'b0;
            write_rejected             <= 1'b0;
            wake_interrupt             <= 1'b0;
        end else begin
            mode_state                 <= state_reg;
            reset_output_low_active    <= rst_out_reg;
            crc_enable                 <= crc_reg;
            main_regulator_output      <= reg_next;
            main_regulator_low_power   <= lp_next;
            watchdog_unit_en           <= wd_next && rst_out_reg;
            watchdog_long_window       <= in_init && rst_out_reg;
            watchdog_config_allowed    <= cfg_mode;
            high_side_switches_en      <= hs_next;
            bridge_drivers_en          <= bd_next;
            bridge_low_side_en         <= ls_next;
            charge_pump_en             <= cp_next;
            current_sense_amplifier_en <= csa_next;
            can_en                     <= can_next;
            can_wake_capable           <= canw_nxt;
            cyclic_sense_en            <= cs_next;
            cyclic_wake_en             <= cw_next;
            supervision_en             <= cfg_mode;
            write_rejected             <= rej_next;
            wake_interrupt             <= irq_next;
        end
    end
endmodule

// File: verilog/opmode_pkg.sv
// shared constants and types for the operating-mode controller
package opmode_pkg;

    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART
    } op_mode_t;

    // host mode requests
    localparam logic [2:0] REQ_NONE    = 3'h0;
    localparam logic [2:0] REQ_NORMAL  = 3'h1;
    localparam logic [2:0] REQ_STOP    = 3'h2;
    localparam logic [2:0] REQ_SLEEP   = 3'h3;
    localparam logic [2:0] REQ_SOFTRST = 3'h4;

    // recovery frames
    localparam logic [31:0] CRC_ON_FRAME  = 32'h67AAAA0E;
    localparam logic [31:0] CRC_OFF_FRAME = 32'hE7AAAAC3;

    // timing
    localparam int CLK_PERIOD_PS        = 4000;
    localparam int STRAP_FILTER_TIME_NS = 10;
    localparam int STRAP_FILTER_CYCLES  =
        (STRAP_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_DELAY_TIME_US  = 10;
    localparam int RESET_DELAY_CYCLES   =
        (RESET_DELAY_TIME_US * 1000000) / CLK_PERIOD_PS;

    // reset values
    localparam logic CRC_EN_RST = 1'b0;

endpackage

// File: verilog/strap_if.sv
// strap filter handshake between the controller and its filter
interface strap_if;
    logic sample_en;
    logic filt_level;
    modport ctrl (output sample_en, input filt_level);
    modport filt (input sample_en, output filt_level);
endinterface

// File: verilog/strap_filter.sv
// strap level filter, running only while sample_en is high
module strap_filter
    import opmode_pkg::*;
#(
    parameter int FILT_CYCLES = STRAP_FILTER_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic strap_level,
    strap_if.filt     sif
);
    localparam int CW = $clog2(FILT_CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    logic          filt_reg;
    wire           differs = (strap_level != filt_reg);
    wire           done    = (cnt_reg == CW'(FILT_CYCLES - 1));

    // level must stand a full filter time before it is taken
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= '0;
            filt_reg <= 1'b1;
        end else if (!sif.sample_en || !differs) begin
            cnt_reg <= '0;
        end else if (done) begin
            cnt_reg  <= '0;
            filt_reg <= strap_level;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign sif.filt_level = filt_reg;
endmodule

// File: test/omc_props.sv
// port-level checks for the operating-mode controller
module omc_props
    import opmode_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        sw_dev_mode,
    input wire logic        frame_valid,
    input wire logic [31:0] frame_data,
    input wire logic        write_req,
    input wire logic        write_exempt,
    input wire logic [2:0]  mode_req,
    input wire logic        cfg_high_side_switches,
    input wire logic        cfg_bridge_drivers,
    input wire logic        wake_event,
    input wire logic        park_brake_event,
    input wire logic        ov_brake_event,
    input wire logic [2:0]  mode_state,
    input wire logic        reset_output_low_active,
    input wire logic        crc_enable,
    input wire logic        main_regulator_output,
    input wire logic        main_regulator_low_power,
    input wire logic        watchdog_unit_en,
    input wire logic        high_side_switches_en,
    input wire logic        bridge_drivers_en,
    input wire logic        charge_pump_en,
    input wire logic        current_sense_amplifier_en,
    input wire logic        can_en,
    input wire logic        supervision_en,
    input wire logic        write_rejected,
    input wire logic        wake_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    // mode held two samples so enables have settled
    a_init_fn_off: assert property (mode_state == 3'h0 && $past(mode_state) == 3'h0 |->
        main_regulator_output && !(high_side_switches_en | bridge_drivers_en
        | charge_pump_en | current_sense_amplifier_en))
        else $error("function on in init mode");
    a_init_can_dev: assert property (mode_state == 3'h0 && $past(mode_state) == 3'h0 |->
        can_en == $past(sw_dev_mode))
        else $error("can enable wrong in init mode");
    a_normal_cfg_pass: assert property (mode_state == 3'h1 && $past(mode_state) == 3'h1 |->
        supervision_en && main_regulator_output
        && bridge_drivers_en == $past(cfg_bridge_drivers)
        && high_side_switches_en == $past(cfg_high_side_switches))
        else $error("normal mode enables wrong");
    a_stop_frozen: assert property (mode_state == 3'h2 && $past(mode_state) == 3'h2 |->
        main_regulator_output && main_regulator_low_power
        && !(bridge_drivers_en | charge_pump_en | current_sense_amplifier_en)
        && high_side_switches_en == $past(cfg_high_side_switches))
        else $error("stop mode enables wrong");
    a_sleep_off: assert property (mode_state == 3'h3 && $past(mode_state) == 3'h3 |->
        !(main_regulator_output | watchdog_unit_en | bridge_drivers_en | charge_pump_en))
        else $error("function on in sleep mode");
    a_restart_off: assert property (mode_state == 3'h4 && $past(mode_state) == 3'h4 |->
        !(watchdog_unit_en | high_side_switches_en | bridge_drivers_en | charge_pump_en))
        else $error("function on in restart mode");
    a_reject_cause: assert property (write_rejected |->
        $past(write_req) && !$past(write_exempt))
        else $error("write rejected without plain write");
    a_stop_reject: assert property (mode_state == 3'h2 && $past(mode_state) == 3'h2
        && $past(mode_req) == REQ_NONE && write_req && !write_exempt |=> write_rejected)
        else $error("plain write in stop not rejected");
    a_irq_cause: assert property (wake_interrupt |->
        $past(wake_event) || $past(park_brake_event) || $past(ov_brake_event))
        else $error("interrupt without event");
    // two quiet cycles so a later frame cannot mask the result
    a_crc_on: assert property (frame_valid && frame_data == CRC_ON_FRAME
        && mode_state == 3'h1 && $past(mode_state) == 3'h1 && $past(mode_req) == REQ_NONE
        ##1 !frame_valid [*2] |-> ##1 crc_enable)
        else $error("crc on frame not obeyed");
    a_crc_off: assert property (frame_valid && frame_data == CRC_OFF_FRAME
        && mode_state == 3'h1 && $past(mode_state) == 3'h1 && $past(mode_req) == REQ_NONE
        ##1 !frame_valid [*2] |-> ##1 !crc_enable)
        else $error("crc off frame not obeyed");
    // the latched strap shows one cycle after the reset output rises
    a_crc_cause: assert property ($changed(crc_enable) |->
        ($past(reset_output_low_active) && !$past(reset_output_low_active, 2))
        || $past(frame_valid, 2) || $past(frame_valid, 3))
        else $error("crc changed without cause");
    c_stop_irq: cover property (mode_state == 3'h2 && wake_interrupt);
    c_reject: cover property (write_rejected);
    c_crc_off: cover property ($fell(crc_enable));
endmodule

bind operating_mode_controller omc_props props_u (.*);

// File: test/host_model.sv
// host stand-in: mode requests, spi frames, writes and configuration levels
module host_model
    import opmode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [2:0]  mode_state,
    output logic      [2:0]  mode_req,
    output logic             frame_valid,
    output logic      [31:0] frame_data,
    output logic             write_req,
    output logic             write_exempt,
    output logic      [8:0]  cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mode_req = REQ_NONE;
        frame_valid = 1'b0;
        frame_data = 32'h5A5A5A5A;
        write_req = 1'b0;
        write_exempt = 1'b0;
        cfg = 9'h000;
    end
    task automatic pulse_mode(input logic [2:0] r);
        @(negedge clk);
        mode_req = r;
        @(negedge clk);
        mode_req = REQ_NONE;
    endtask
    // force_any lets a scenario break the normal-only habit on purpose
    task automatic send_frame(input logic [31:0] d, input bit force_any);
        if (force_any || mode_state == 3'h1) begin
            @(negedge clk);
            frame_data = d;
            frame_valid = 1'b1;
            @(negedge clk);
            frame_valid = 1'b0;
            frame_data = ~d;
        end
    endtask
    task automatic send_write(input logic ex);
        @(negedge clk);
        write_req = 1'b1;
        write_exempt = ex;
        @(negedge clk);
        write_req = 1'b0;
    endtask
    // settings freeze in stop and sleep, so only touch them in normal
    task automatic configure(input logic [8:0] v);
        @(negedge clk);
        if (mode_state == 3'h1) begin
            cfg = v;
        end
    endtask
endmodule

// File: test/operating_mode_controller_tb.sv
// self-checking bench for the operating-mode controller
module operating_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import opmode_pkg::*;
    logic clk, rst_b, crc_strap_pin, regulator_above_threshold, por_flag, sw_dev_mode;
    logic restart_event, wake_event, park_brake_event, ov_brake_event, low_side_brake_req;
    logic frame_valid, write_req, write_exempt;
    logic [31:0] frame_data;
    logic [2:0] mode_req, mode_state, ev;
    logic [8:0] cfg, v;
    logic reset_output_low_active, crc_enable, main_regulator_output, main_regulator_low_power;
    logic watchdog_unit_en, watchdog_long_window, watchdog_config_allowed, high_side_switches_en;
    logic bridge_drivers_en, bridge_low_side_en, charge_pump_en, current_sense_amplifier_en;
    logic can_en, can_wake_capable, cyclic_sense_en, cyclic_wake_en, supervision_en;
    logic write_rejected, wake_interrupt;
    int error_cnt = 0;
    int n_checks = 0;
    int exp_mode = 0;
    int exp_crc = 0;
    int cyc = 0;
    assign {ov_brake_event, park_brake_event, wake_event} = ev;
    // short reset delay and filter keep the run brief
    operating_mode_controller #(.RESET_DELAY(8), .FILT_CYCLES(2)) dut_u (
        .*,
        .cfg_watchdog_unit           (cfg[0]),
        .cfg_high_side_switches      (cfg[1]),
        .cfg_bridge_drivers          (cfg[2]),
        .cfg_charge_pump             (cfg[3]),
        .cfg_current_sense_amplifier (cfg[4]),
        .cfg_can                     (cfg[5]),
        .cfg_can_wake_capable        (cfg[6]),
        .cfg_cyclic_sense            (cfg[7]),
        .cfg_cyclic_wake             (cfg[8])
    );
    host_model host_u (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // model of legal mode moves; illegal requests leave the mode alone
    task automatic go(input logic [2:0] r);
        host_u.pulse_mode(r);
        case (exp_mode)
            0: exp_mode = (r == REQ_NORMAL) ? 1 : 0;
            1: exp_mode = (r == REQ_STOP) ? 2 : (r == REQ_SLEEP) ? 3 : (r == REQ_SOFTRST) ? 0 : 1;
            2: exp_mode = (r == REQ_NORMAL) ? 1 : (r == REQ_SOFTRST) ? 0 : 2;
            default: ;
        endcase
        repeat (3) @(negedge clk);
        check(mode_state, exp_mode[2:0]);
    endtask
    task automatic frame(input logic [31:0] d, input bit f);
        host_u.send_frame(d, f);
        if (exp_mode == 1 && d === CRC_ON_FRAME) exp_crc = 1;
        if (exp_mode == 1 && d === CRC_OFF_FRAME) exp_crc = 0;
        repeat (4) @(negedge clk);
        check(crc_enable, exp_crc[0]);
    endtask
    task automatic wait_for(input logic [2:0] m);
        for (int i = 0; i < 60 && mode_state !== m; i++) @(negedge clk);
        check(mode_state, m);
    endtask
    task automatic power_up(input logic strap, input logic por);
        rst_b = 1'b0;
        crc_strap_pin = strap;
        por_flag = por;
        exp_mode = 0;
        repeat (8) @(negedge clk);
        check({mode_state, main_regulator_output, reset_output_low_active}, 5'h02);
        rst_b = 1'b1;
        for (int i = 0; i < 60 && reset_output_low_active !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        exp_crc = (por && !strap) ? 1 : 0;
        check(crc_enable, exp_crc[0]);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_b, regulator_above_threshold, sw_dev_mode, restart_event} = 4'h4;
        {crc_strap_pin, por_flag, low_side_brake_req, ev} = 6'h10;
        void'($urandom(27));
        power_up(1'b0, 1'b1);
        check({watchdog_unit_en, watchdog_long_window, can_en}, 3'h6);
        sw_dev_mode = 1'b1;
        repeat (3) @(negedge clk);
        check(can_en, 1'b1);
        sw_dev_mode = 1'b0;
        go(REQ_STOP);
        go(REQ_NORMAL);
        for (int i = 0; i < 4; i++) begin
            v = 9'($urandom);
            host_u.configure(v);
            repeat (3) @(negedge clk);
            check({watchdog_unit_en, watchdog_config_allowed, can_wake_capable, cyclic_wake_en,
                cyclic_sense_en, can_en, current_sense_amplifier_en, charge_pump_en,
                bridge_drivers_en, high_side_switches_en, supervision_en},
                {v[0], 2'h2, v[8:7], v[5:1], 1'b1});
        end
        frame(CRC_OFF_FRAME, 1'b0);
        frame(32'h67AAAA0F, 1'b0);
        frame(CRC_ON_FRAME, 1'b0);
        frame(CRC_OFF_FRAME, 1'b0);
        go(REQ_STOP);
        host_u.configure(~v);
        repeat (3) @(negedge clk);
        check({high_side_switches_en, bridge_drivers_en, main_regulator_low_power},
            {v[1], 2'h1});
        frame(CRC_ON_FRAME, 1'b1);
        // rejection flag stands for one cycle only, so look as the request drops
        host_u.send_write(1'b0);
        check(write_rejected, 1'b1);
        host_u.send_write(1'b1);
        check(write_rejected, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            ev = 3'h1 << i;
            @(negedge clk);
            ev = 3'h0;
            check({wake_interrupt, mode_state}, 4'hA);
        end
        low_side_brake_req = 1'b1;
        repeat (3) @(negedge clk);
        check(bridge_low_side_en, 1'b1);
        low_side_brake_req = 1'b0;
        go(REQ_NORMAL);
        // crc on before sleep so the restart latch has something to undo
        frame(CRC_ON_FRAME, 1'b0);
        go(REQ_SLEEP);
        check(main_regulator_output, 1'b0);
        check({can_en, can_wake_capable}, {v[5] & ~v[6], v[5] & v[6]});
        low_side_brake_req = 1'b1;
        repeat (3) @(negedge clk);
        check(bridge_low_side_en, 1'b1);
        low_side_brake_req = 1'b0;
        crc_strap_pin = 1'b1;
        ev = 3'h1;
        @(negedge clk);
        ev = 3'h0;
        wait_for(3'h4);
        check({reset_output_low_active, cyclic_sense_en, cyclic_wake_en,
            high_side_switches_en}, 4'h0);
        exp_mode = 1;
        wait_for(3'h1);
        repeat (3) @(negedge clk);
        check(crc_enable, 1'b0);
        go(REQ_SOFTRST);
        power_up(1'b0, 1'b0);
        complete_run();
    end
endmodule
